// *** logic/gpar_regs.sv ***
// gigabit advertisement, gigabit status and extended status registers with interrupt logic
//
// The implementer's own choice: the plain strobed port.
`default_nettype none

module gpar_regs (
  input  wire logic                          I_CLK,      // 25 MHz system clock
  input  wire logic                          I_RESETN,   // synchronous reset, active low
  input  wire logic [gpar_pkg::GPAR_ADDR_W-1:0] I_ADDR,  // register address
  input  wire logic [gpar_pkg::GPAR_DATA_W-1:0] I_WDATA, // write data
  input  wire logic                          I_WR,       // write strobe
  input  wire logic                          I_RD,       // read strobe
  input  wire logic                          I_HD_STRAP, // half_duplex_strap_default pin
  input  wire gpar_pkg::gpar_link_type       I_LINK,     // status from phy core
  input  wire gpar_pkg::gpar_apply_type      I_APPLY,    // apply conditions
  output var  logic [gpar_pkg::GPAR_DATA_W-1:0] O_RDATA, // read data, cycle after read
  output var  logic                          O_IRQ,      // level interrupt
  output var  logic                          O_ADV_FD,   // advertised gigabit full duplex
  output var  logic                          O_ADV_HD,   // advertised gigabit half duplex
  output var  logic                          O_ADV_APPLY // pulse: advertisement applied
);
  import gpar_pkg::*;

  function automatic logic hit(input logic [GPAR_ADDR_W-1:0] addr,
                               input logic [GPAR_ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  // strap synchroniser and load flag
  logic                   strap_meta_q;
  logic                   strap_sync_q;
  logic                   strap_done_q;

  // advertisement: written value and value in effect
  logic [1:0]             adv_wr_q;
  logic [1:0]             adv_wr_d;
  logic [1:0]             adv_act_q;
  logic [1:0]             adv_act_d;
  logic [GPAR_RSVD_W-1:0] rsvd_q;
  logic [GPAR_RSVD_W-1:0] rsvd_d;

  // edge history of apply conditions
  logic                   pdown_prev_q;
  logic                   link_prev_q;

  // status
  logic                   fault_q;
  logic                   fault_d;
  logic [GPAR_LIVE_W-1:0] live_q;
  logic [GPAR_LIVE_W-1:0] live_d;
  logic [GPAR_CNT_W-1:0]  idle_cnt;

  // interrupts
  logic [GPAR_INT_W-1:0]  ists_q;
  logic [GPAR_INT_W-1:0]  ists_d;
  logic [GPAR_INT_W-1:0]  ien_q;
  logic [GPAR_INT_W-1:0]  ien_d;
  logic [GPAR_INT_W-1:0]  int_evt;

  // bus outputs
  logic [GPAR_DATA_W-1:0] rdata_q;
  logic [GPAR_DATA_W-1:0] rdata_d;
  logic                   irq_q;
  logic                   apply_q;

  // address decode
  wire wr_adv  = I_WR && hit(I_ADDR, GPAR_OFF_ADV);
  wire wr_iclr = I_WR && hit(I_ADDR, GPAR_OFF_ICLR);
  wire wr_ien  = I_WR && hit(I_ADDR, GPAR_OFF_IEN);
  wire rd_sts  = I_RD && hit(I_ADDR, GPAR_OFF_STS);
  wire sw_rst  = I_APPLY.sw_reset;

  // pending bits take effect on any of these
  wire pdown_exit = pdown_prev_q && !I_APPLY.power_down;
  wire link_loss  = link_prev_q && !I_APPLY.link_up;
  wire apply_evt  = sw_rst || I_APPLY.an_restart || pdown_exit || link_loss;

  // half duplex comes from the strap until the first cycle after reset
  wire hd_base = strap_done_q ? adv_wr_q[0] : strap_sync_q;

  assign adv_wr_d  = wr_adv ? {I_WDATA[GPAR_ADV_FD], I_WDATA[GPAR_ADV_HD]}
                            : {adv_wr_q[1], hd_base};
  assign adv_act_d = apply_evt     ? adv_wr_d
                   : !strap_done_q ? {adv_act_q[1], strap_sync_q}
                   : adv_act_q;
  // reserved bits are plain storage, untouched by soft reset
  assign rsvd_d    = wr_adv ? I_WDATA[GPAR_RSVD_W-1:0] : rsvd_q;

  // fault: soft reset first, then set wins over read clear
  assign fault_d = sw_rst           ? 1'b0
                 : I_LINK.ms_fault  ? 1'b1
                 : rd_sts           ? 1'b0
                 : fault_q;

  assign live_d = sw_rst ? '0
                : {I_LINK.ms_master, I_LINK.local_rx_ok, I_LINK.remote_rx_ok,
                   I_LINK.lp_full_duplex, I_LINK.lp_half_duplex};

  // interrupt status: events set, write-one clears, set wins
  assign int_evt[GPAR_INT_FAULT] = I_LINK.ms_fault;
  assign int_evt[GPAR_INT_IDLE]  = I_LINK.idle_error;
  assign int_evt[GPAR_INT_APPLY] = apply_evt;
  assign ists_d = (ists_q & ~(wr_iclr ? I_WDATA[GPAR_INT_W-1:0] : '0)) | int_evt;
  assign ien_d  = wr_ien ? I_WDATA[GPAR_INT_W-1:0] : ien_q;

  // read data selection
  wire [GPAR_DATA_W-1:0] adv_word =
    {6'h00, adv_wr_q, rsvd_q};
  wire [GPAR_DATA_W-1:0] sts_word =
    {fault_q, live_q, 2'h0, idle_cnt};
  wire [GPAR_DATA_W-1:0] ists_word = {13'h0000, ists_q};
  wire [GPAR_DATA_W-1:0] ien_word  = {13'h0000, ien_q};

  assign rdata_d = !I_RD                        ? '0
                 : hit(I_ADDR, GPAR_OFF_ADV)    ? adv_word
                 : hit(I_ADDR, GPAR_OFF_STS)    ? sts_word
                 : hit(I_ADDR, GPAR_OFF_EXT)    ? GPAR_EXT_VAL
                 : hit(I_ADDR, GPAR_OFF_ISTS)   ? ists_word
                 : hit(I_ADDR, GPAR_OFF_IEN)    ? ien_word
                 : '0;

  // synchroniser, no reset so it is settled at release
  always_ff @(posedge I_CLK)
  begin
    strap_meta_q <= I_HD_STRAP;
    strap_sync_q <= strap_meta_q;
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      strap_done_q <= 1'b0;
      adv_wr_q     <= {GPAR_ADV_FD_RST, GPAR_ADV_HD_RST};
      adv_act_q    <= {GPAR_ADV_FD_RST, GPAR_ADV_HD_RST};
      rsvd_q       <= GPAR_RSVD_RST;
      pdown_prev_q <= 1'b0;
      link_prev_q  <= 1'b0;
    end
    else
    begin
      strap_done_q <= 1'b1;
      adv_wr_q     <= adv_wr_d;
      adv_act_q    <= adv_act_d;
      rsvd_q       <= rsvd_d;
      pdown_prev_q <= I_APPLY.power_down;
      link_prev_q  <= I_APPLY.link_up;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      fault_q <= 1'b0;
      live_q  <= '0;
      ists_q  <= '0;
      ien_q   <= GPAR_IEN_RST;
    end
    else
    begin
      fault_q <= fault_d;
      live_q  <= live_d;
      ists_q  <= ists_d;
      ien_q   <= ien_d;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RESETN)
    begin
      rdata_q <= '0;
      irq_q   <= 1'b0;
      apply_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      irq_q   <= |(ists_d & ien_d);
      apply_q <= apply_evt;
    end
  end

  // idle errors since last status read, saturating
  gpar_sat_cnt #(
    .W        (GPAR_CNT_W)
  ) u_idle_cnt (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_inc    (I_LINK.idle_error),
    .i_clr    (rd_sts),
    .i_zero   (sw_rst),
    .o_count  (idle_cnt)
  );

  assign O_RDATA     = rdata_q;
  assign O_IRQ       = irq_q;
  assign O_ADV_FD    = adv_act_q[1];
  assign O_ADV_HD    = adv_act_q[0];
  assign O_ADV_APPLY = apply_q;

  // checks
  property p_adv_hold;
    @(posedge I_CLK) disable iff (!I_RESETN)
      (strap_done_q && !apply_evt) |=> ($stable(O_ADV_FD) && $stable(O_ADV_HD));
  endproperty
  a_adv_hold: assert property (p_adv_hold) else $error("advertisement changed without apply");

  property p_adv_apply;
    @(posedge I_CLK) disable iff (!I_RESETN)
      (strap_done_q && apply_evt && !wr_adv) |=> ((adv_act_q == adv_wr_q) && O_ADV_APPLY);
  endproperty
  a_adv_apply: assert property (p_adv_apply) else $error("pending advertisement not applied");

  property p_fd_reset;
    @(posedge I_CLK) disable iff (!I_RESETN)
      $rose(I_RESETN) |-> (O_ADV_FD && adv_wr_q[1] && (rsvd_q == GPAR_RSVD_RST));
  endproperty
  a_fd_reset: assert property (p_fd_reset) else $error("full duplex advertisement not set after reset");

  property p_hd_strap;
    @(posedge I_CLK) disable iff (!I_RESETN)
      ($rose(strap_done_q) && !$past(wr_adv)) |-> (adv_wr_q[0] == $past(strap_sync_q)) && (O_ADV_HD == $past(strap_sync_q));
  endproperty
  a_hd_strap: assert property (p_hd_strap) else $error("half duplex advertisement not taken from strap");

  property p_fault_set;
    @(posedge I_CLK) disable iff (!I_RESETN)
      (I_LINK.ms_fault && !sw_rst) |=> fault_q ##1 (fault_q || $past(rd_sts) || $past(sw_rst));
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault flag not latched");

  property p_fault_clear;
    @(posedge I_CLK) disable iff (!I_RESETN)
      (rd_sts && !I_LINK.ms_fault) |=> !fault_q;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault flag not cleared by status read");

  property p_fault_keep;
    @(posedge I_CLK) disable iff (!I_RESETN)
      (fault_q && !rd_sts && !sw_rst) |=> fault_q;
  endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("fault flag dropped without a read");

  property p_live;
    @(posedge I_CLK) disable iff (!I_RESETN)
      (rd_sts && $past(I_RESETN) && !$past(sw_rst))
        |=> (O_RDATA[GPAR_STS_FAULT-1:GPAR_STS_LIVE] == $past({I_LINK.ms_master, I_LINK.local_rx_ok,
             I_LINK.remote_rx_ok, I_LINK.lp_full_duplex, I_LINK.lp_half_duplex}, 2));
  endproperty
  a_live: assert property (p_live) else $error("status levels read back wrong");

  property p_cnt_clear;
    @(posedge I_CLK) disable iff (!I_RESETN)
      (rd_sts && !I_LINK.idle_error) |=> (idle_cnt == '0);
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("idle count not cleared by read");

  property p_cnt_inc;
    @(posedge I_CLK) disable iff (!I_RESETN)
      (I_LINK.idle_error && !rd_sts && !sw_rst && !(&idle_cnt))
        |=> (idle_cnt == $past(idle_cnt) + GPAR_CNT_W'(1));
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("idle count did not step");

  property p_cnt_sat;
    @(posedge I_CLK) disable iff (!I_RESETN)
      ((&idle_cnt) && !rd_sts && !sw_rst) |=> (&idle_cnt);
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("idle count wrapped");

  property p_ext;
    @(posedge I_CLK) disable iff (!I_RESETN)
      (I_RD && hit(I_ADDR, GPAR_OFF_EXT)) |=> (O_RDATA == GPAR_EXT_VAL);
  endproperty
  a_ext: assert property (p_ext) else $error("extended status value wrong");

  property p_irq;
    @(posedge I_CLK) disable iff (!I_RESETN)
      (I_LINK.idle_error && ien_q[GPAR_INT_IDLE] && !wr_ien) |=> O_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled event gave no interrupt");

endmodule : gpar_regs

`default_nettype wire

// *** logic/gpar_sat_cnt.sv ***
// saturating event counter with clear on read and synchronous zeroing
`default_nettype none

module gpar_sat_cnt #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_clk,    // system clock
  input  wire logic         i_resetn, // synchronous reset, active low
  input  wire logic         i_inc,    // one event this cycle
  input  wire logic         i_clr,    // clear from a read
  input  wire logic         i_zero,   // soft reset, overrides all
  output var  logic [W-1:0] o_count   // current count
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  wire          sat = &count_q;

  // an event in the clearing cycle is kept as the first new count
  assign count_d = i_zero ? '0
                 : i_clr  ? (i_inc ? W'(1) : '0)
                 : (i_inc && !sat) ? count_q + W'(1)
                 : count_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      count_q <= '0;
    else
      count_q <= count_d;
  end

  assign o_count = count_q;

endmodule : gpar_sat_cnt

`default_nettype wire

// *** shared/gpar_pkg.sv ***
// package: register map, field layout and carriers of the gigabit advertisement and status bank
// Overview of operation
// - written advertisement bits wait; applied on soft reset, restart, power-up or link loss
// - full-duplex advertisement bit 9 resets to one; one advertises, zero withholds
// - half-duplex advertisement bit 8 loads from the strap after hardware reset
// - fault flag bit 15 latches on a fault and clears on a status read
// - status bit 14 shows resolved role, one for master; resets to zero
// - status bit 13 shows local receiver operational; resets to zero
// - status bit 12 shows remote receiver operational; resets to zero
// - status bits 11 and 10 show partner gigabit full and half duplex ability
// - status bits 7:0 count idle errors since last status read; read clears
// - idle error count saturates at all ones and never wraps
// - extended bits 15 and 14 always read zero
// - extended bits 13 and 12 always read one
// - extended bits 11:0 always read zero
`default_nettype none

package gpar_pkg;

  localparam int unsigned GPAR_DATA_W    = 16;
  localparam int unsigned GPAR_ADDR_W    = 5;
  localparam int unsigned GPAR_CNT_W     = 8;
  localparam int unsigned GPAR_RSVD_W    = 8;
  localparam int unsigned GPAR_LIVE_W    = 5;
  localparam int unsigned GPAR_INT_W     = 3;

  // register addresses
  localparam logic [4:0]  GPAR_OFF_ADV   = 5'h09;
  localparam logic [4:0]  GPAR_OFF_STS   = 5'h0a;
  localparam logic [4:0]  GPAR_OFF_EXT   = 5'h0f;
  localparam logic [4:0]  GPAR_OFF_ISTS  = 5'h10;
  localparam logic [4:0]  GPAR_OFF_ICLR  = 5'h11;
  localparam logic [4:0]  GPAR_OFF_IEN   = 5'h12;

  // advertisement field positions and reset values
  localparam int unsigned GPAR_ADV_FD    = 9;
  localparam int unsigned GPAR_ADV_HD    = 8;
  localparam logic        GPAR_ADV_FD_RST = 1'h1;
  localparam logic        GPAR_ADV_HD_RST = 1'h0;
  localparam logic [7:0]  GPAR_RSVD_RST  = 8'h00;

  // status field positions
  localparam int unsigned GPAR_STS_FAULT = 15;
  localparam int unsigned GPAR_STS_LIVE  = 10;

  // extended status: copper gigabit full and half duplex only
  localparam logic [15:0] GPAR_EXT_VAL   = 16'h3000;

  // interrupt bits
  localparam int unsigned GPAR_INT_FAULT = 0;
  localparam int unsigned GPAR_INT_IDLE  = 1;
  localparam int unsigned GPAR_INT_APPLY = 2;
  localparam logic [2:0]  GPAR_IEN_RST   = 3'h0;

  // link-side status from the phy core, same clock
  typedef struct packed {
    logic ms_fault;
    logic ms_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic lp_full_duplex;
    logic lp_half_duplex;
    logic idle_error;
  } gpar_link_type;

  // conditions that make pending advertisement bits take effect
  typedef struct packed {
    logic sw_reset;
    logic an_restart;
    logic power_down;
    logic link_up;
  } gpar_apply_type;

endpackage : gpar_pkg

`default_nettype wire

// *** test/gpar_link_model.sv ***
// link-side model: live status levels, fault events and idle error bursts
`default_nettype none

module gpar_link_model (
  input  wire logic                    i_clk,      // system clock
  input  wire logic                    i_resetn,   // synchronous reset, active low
  input  wire logic [4:0]              i_live,     // master, local rx, remote rx, lp fd, lp hd
  input  wire logic                    i_fault,    // role fault condition
  input  wire logic                    i_idle_go,  // start an idle error burst
  input  wire logic [8:0]              i_idle_num, // burst length
  output var  gpar_pkg::gpar_link_type o_link      // status toward the bank
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpar_pkg::*;

  logic [8:0] left_q;

  // one idle error per cycle while the burst lasts
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      left_q <= 9'h000;
    else if (i_idle_go)
      left_q <= i_idle_num;
    else if (left_q != 9'h000)
      left_q <= left_q - 9'h001;
  end

  assign o_link = {i_fault, i_live, left_q != 9'h000};
endmodule : gpar_link_model

`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the advertisement and status register bank
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpar_pkg::*;

  logic           clk, resetn, wr, rd, strap, fault, idle_go, irq, fd, hd, applied;
  logic [4:0]     addr, live;
  logic [8:0]     idle_num;
  logic [15:0]    wdata, rdata, v;
  gpar_link_type  link;
  gpar_apply_type app;
  int             fails, tests_run;

  gpar_link_model gpar_link_model_inst (.i_clk(clk), .i_resetn(resetn), .i_live(live), .i_fault(fault),
    .i_idle_go(idle_go), .i_idle_num(idle_num), .o_link(link));

  gpar_regs gpar_regs_inst (.I_CLK(clk), .I_RESETN(resetn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .I_HD_STRAP(strap), .I_LINK(link), .I_APPLY(app), .O_RDATA(rdata), .O_IRQ(irq),
    .O_ADV_FD(fd), .O_ADV_HD(hd), .O_ADV_APPLY(applied));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  task automatic wait_edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_edges

  task automatic t_reset();
    chk("adv_fd", 16'h0001, {15'h0, fd});
    chk("adv_hd", 16'h0001, {15'h0, hd});
    bus_rd(GPAR_OFF_ADV, v);
    chk("adv reg", 16'h0300, v);
    bus_wr(GPAR_OFF_EXT, 16'hffff);
    bus_rd(GPAR_OFF_EXT, v);
    chk("ext reg", 16'h3000, v);
    wait_edges(1);
    chk("rdata idle", 16'h0000, rdata);
    bus_rd(GPAR_OFF_STS, v);
    chk("status", 16'h0000, v);
    bus_rd(5'h1f, v);
    chk("unmapped", 16'h0000, v);
    bus_rd(GPAR_OFF_IEN, v);
    chk("irq enable", 16'h0000, v);
    $display("test reset done");
  endtask : t_reset

  task automatic t_apply();
    logic [15:0] val;
    logic [1:0]  now;
    now = 2'b11;
    for (int k = 0; k < 4; k++)
    begin
      val = k[0] ? 16'h0200 : 16'h0100;
      bus_wr(GPAR_OFF_ADV, val);
      bus_rd(GPAR_OFF_ADV, v);
      chk("pending adv", val, v);
      chk("held adv", {14'h0, now}, {14'h0, fd, hd});
      @(posedge clk);
      app <= gpar_apply_type'(4'b1000 >> k);
      @(posedge clk);
      app <= '0;
      if (k >= 2)
        @(posedge clk);
      #1;
      now = val[9:8];
      chk("applied adv", {14'h0, now}, {14'h0, fd, hd});
      chk("apply pulse", 16'h0001, {15'h0, applied});
      wait_edges(1);
      chk("apply pulse end", 16'h0000, {15'h0, applied});
    end
    bus_rd(GPAR_OFF_ISTS, v);
    chk("apply irq status", 16'h0004, v);
    $display("test apply done");
  endtask : t_apply

  task automatic t_live();
    logic [4:0] pat [2] = '{5'b10110, 5'b01001};
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      live <= pat[k];
      wait_edges(2);
      bus_rd(GPAR_OFF_STS, v);
      chk("live status", {1'b0, pat[k], 10'h000}, v);
    end
    @(posedge clk);
    live <= 5'b00000;
    wait_edges(2);
    $display("test live done");
  endtask : t_live

  task automatic t_fault();
    bus_wr(GPAR_OFF_ICLR, 16'h0007);
    bus_wr(GPAR_OFF_IEN, 16'h0001);
    @(posedge clk);
    idle_go  <= 1'b1;
    idle_num <= 9'h002;
    @(posedge clk);
    idle_go  <= 1'b0;
    wait_edges(5);
    chk("masked irq", 16'h0000, {15'h0, irq});
    @(posedge clk);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    wait_edges(4);
    chk("fault irq", 16'h0001, {15'h0, irq});
    bus_rd(GPAR_OFF_ISTS, v);
    chk("irq status", 16'h0003, v);
    bus_rd(GPAR_OFF_STS, v);
    chk("fault and count", 16'h8002, v);
    bus_rd(GPAR_OFF_STS, v);
    chk("cleared by read", 16'h0000, v);
    @(posedge clk);
    fault <= 1'b1;
    live  <= 5'b11111;
    @(posedge clk);
    fault <= 1'b0;
    live  <= 5'b00000;
    app   <= gpar_apply_type'(4'h8);
    @(posedge clk);
    app   <= '0;
    bus_rd(GPAR_OFF_STS, v);
    chk("soft reset status", 16'h0000, v);
    bus_wr(GPAR_OFF_ICLR, 16'h0003);
    wait_edges(2);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    $display("test fault done");
  endtask : t_fault

  task automatic t_idle();
    bus_wr(GPAR_OFF_IEN, 16'h0002);
    @(posedge clk);
    idle_go  <= 1'b1;
    idle_num <= 9'h12c;
    @(posedge clk);
    idle_go  <= 1'b0;
    wait_edges(305);
    chk("idle irq", 16'h0001, {15'h0, irq});
    bus_rd(GPAR_OFF_STS, v);
    chk("saturated count", 16'h00ff, v);
    bus_rd(GPAR_OFF_STS, v);
    chk("count after read", 16'h0000, v);
    bus_wr(GPAR_OFF_ICLR, 16'h0002);
    wait_edges(2);
    chk("idle irq cleared", 16'h0000, {15'h0, irq});
    $display("test idle done");
  endtask : t_idle

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    final_report();
  end

  initial
  begin
    fails = 0;
    tests_run = 0;
    {resetn, wr, rd, fault, idle_go} = '0;
    strap = 1'b1;
    addr = 5'h00;
    wdata = 16'h0000;
    live = 5'h00;
    idle_num = 9'h000;
    app = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    wait_edges(2);
    t_reset();
    t_apply();
    t_live();
    t_fault();
    t_idle();
    final_report();
  end
endmodule : testbench

`default_nettype wire
